// ---- i2c_host_model.sv ----
// I2C master model standing in for the host microcontroller
`timescale 1ns/1ps
module i2c_host_model (
	input  wire logic       clk_in,
	input  wire logic       sda_line_in,
	output logic            scl_out,
	output logic            sda_low_out,
	output logic [7:0]      rd_byte_out,
	output logic            rd_done_out,
	output logic            nacked_out
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
		rd_byte_out = 8'h00;
		rd_done_out = 1'b0;
		nacked_out = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick

	// SDA moves only while SCL is low, four phases of two clocks
	task automatic put_bit(input logic b, output logic got);
		tick(2);
		sda_low_out = ~b;
		tick(2);
		scl_out = 1'b1;
		tick(2);
		got = sda_line_in;
		tick(2);
		scl_out = 1'b0;
	endtask : put_bit

	// Sending 8'hFF releases the line, so the same task reads a byte
	task automatic put_byte(input logic [7:0] d, input logic ack_bit,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
		put_bit(ack_bit, a);
	endtask : put_byte

	task automatic start_cond();
		sda_low_out = 1'b0;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		sda_low_out = 1'b1;
		tick(4);
		scl_out = 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		tick(2);
		sda_low_out = 1'b1;
		tick(2);
		scl_out = 1'b1;
		tick(2);
		sda_low_out = 1'b0;
		tick(4);
	endtask : stop_cond

	// Single-byte write, or pointer write then repeated start and read
	task automatic access(input logic [6:0] dev, input logic [7:0] ra,
		input logic [7:0] wd, input logic rd);
		logic [7:0] q;
		logic       a;
		nacked_out = 1'b0;
		start_cond();
		put_byte({dev, 1'b0}, 1'b1, q, a);
		nacked_out = nacked_out | a;
		put_byte(ra, 1'b1, q, a);
		nacked_out = nacked_out | a;
		if (rd) begin
			start_cond();
			put_byte({dev, 1'b1}, 1'b1, q, a);
			nacked_out = nacked_out | a;
			put_byte(8'hFF, 1'b1, q, a);
			rd_byte_out = q;
			rd_done_out = 1'b1;
			tick(1);
			rd_done_out = 1'b0;
		end else begin
			put_byte(wd, 1'b1, q, a);
			nacked_out = nacked_out | a;
		end
		stop_cond();
	endtask : access
endmodule : i2c_host_model

// ---- tb_top.sv ----
// Self-checking bench for the status and control register bank
`timescale 1ns/1ps
`include "typec_regs_cfg.svh"
module tb_top;
	localparam int unsigned DIS = 20;
	logic clk_in, rst_n_in, scl_in, addr0_in, supply_in_range_in;
	logic supply_near_zero_in, supply_present_in, plug_power_above_in;
	logic pullup_overvoltage_in, pullup_good_in, thermal_over_in;
	logic partner_attached_in, active_role_in, plug_power_supplied_in;
	logic attached_channel_pin_in, nvm_standby_in, nvm_discharge_en_in;
	logic nvm_supply_en_in, sda_out, sda_oe_out, alert_n_out;
	logic analog_power_on_out, attach_qualified_out, orientation_out;
	logic plug_power_supply_enable_out, plug_power_discharge_out;
	logic plug_power_monitor_enable_out, plug_power_threshold_select_out;
	logic [5:0] switch_fault_in;
	logic [2:0] attached_mode_in, nvm_alert_mask_in;
	logic [1:0] sink_current_in, nvm_offer_in, source_current_offer_out;
	logic [4:0] connection_state_code_in;
	logic [3:0] nvm_limit_code_in, switch_current_limit_code_out;
	logic       sda_low, rd_done, nacked;
	logic [7:0] rd_byte;
	logic [7:0] exp_q[$];
	logic [1:0] eo;
	logic [3:0] el;
	int         seed = 74490;
	int         comparisons = 0;
	int         miscompares = 0;
	wire logic  sda_in = ~(sda_low | sda_oe_out);
	wire logic [6:0] dev = {`DEV_ADDR_HIGH, addr0_in};

	typec_status_control_regs #(.DISCHARGE_CYCLES(DIS)) dut (.*);
	i2c_host_model host (.clk_in(clk_in), .sda_line_in(sda_in),
		.scl_out(scl_in), .sda_low_out(sda_low), .rd_byte_out(rd_byte),
		.rd_done_out(rd_done), .nacked_out(nacked));

	always #25 clk_in = ~clk_in;

	task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check_byte

	task automatic check_pin(input logic g, input logic e);
		check_byte({7'h0, g}, {7'h0, e});
	endtask : check_pin

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.access(dev, a, 8'h00, 1'b1);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.access(dev, a, d, 1'b0);
	endtask : wr

	task automatic print_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// Read results are matched against the oldest note
	always @(posedge clk_in) begin
		if (rd_done === 1'b1)
			check_byte(rd_byte, exp_q.pop_front());
	end

	initial begin
		#(50 * 100000);
		miscompares++;
		print_verdict();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		{clk_in, rst_n_in, supply_in_range_in, supply_present_in} = 4'h0;
		{plug_power_above_in, pullup_overvoltage_in, thermal_over_in} = 3'h0;
		{partner_attached_in, active_role_in, plug_power_supplied_in} = 3'h0;
		{attached_channel_pin_in, switch_fault_in, sink_current_in} = 9'h0;
		{addr0_in, supply_near_zero_in, pullup_good_in} = 3'h7;
		connection_state_code_in = 5'h00;
		attached_mode_in = 3'h1;
		{nvm_standby_in, nvm_discharge_en_in, nvm_supply_en_in} = 3'h6;
		nvm_alert_mask_in = 3'h0;
		nvm_offer_in = 2'($unsigned($random(seed)) % 3);
		nvm_limit_code_in = 4'($unsigned($random(seed)) % 11);
		eo = nvm_offer_in;
		el = nvm_limit_code_in;
		repeat (4) @(posedge clk_in);
		#1 rst_n_in = 1'b1;
		tick(4);
		rd(`ADDR_CAP_CTRL, {eo, 6'h30});
		rd(`ADDR_SWITCH_LIMIT, {4'h0, el});
		rd(`ADDR_PLUG_MON_CTRL, 8'hA0);
		rd(`ADDR_MON_STATUS, 8'h04);
		rd(`ADDR_FAULT_STATUS, 8'h40);
		rd(`ADDR_OP_STATUS, 8'h00);
		rd(8'h05, 8'h00);
		for (int c = 0; c < 4; c++) begin
			if (c < 3)
				eo = 2'(c);
			wr(`ADDR_CAP_CTRL, {2'(c), 6'h1F});
			rd(`ADDR_CAP_CTRL, {eo, 6'h31});
			check_byte({6'h0, source_current_offer_out}, {6'h0, eo});
		end
		check_pin(plug_power_supply_enable_out, 1'b1);
		for (int c = 0; c < 16; c++) begin
			if (c <= 10)
				el = 4'(c);
			wr(`ADDR_SWITCH_LIMIT, {4'hF, 4'(c)});
			rd(`ADDR_SWITCH_LIMIT, {4'h0, el});
		end
		check_byte({4'h0, switch_current_limit_code_out}, {4'h0, el});
		{plug_power_above_in, supply_in_range_in} = 2'h3;
		tick(6);
		check_pin(alert_n_out, 1'b0);
		rd(`ADDR_MON_CHANGE, 8'h09);
		rd(`ADDR_MON_STATUS, 8'h0D);
		rd(`ADDR_MON_CHANGE, 8'h00);
		rd(`ADDR_ALERT_SUMMARY, 8'h20);
		check_pin(alert_n_out, 1'b1);
		wr(`ADDR_PLUG_MON_CTRL, 8'h40);
		rd(`ADDR_PLUG_MON_CTRL, 8'h60);
		check_pin(plug_power_threshold_select_out, 1'b1);
		rd(`ADDR_MON_STATUS, 8'h0C);
		rd(`ADDR_MON_CHANGE, 8'h01);
		rd(`ADDR_ALERT_SUMMARY, 8'h20);
		{thermal_over_in, pullup_overvoltage_in, switch_fault_in} = 8'hE0;
		tick(6);
		thermal_over_in = 1'b0;
		tick(6);
		rd(`ADDR_FAULT_CHANGE, 8'hA4);
		rd(`ADDR_FAULT_STATUS, 8'hE0);
		rd(`ADDR_FAULT_CHANGE, 8'h00);
		rd(`ADDR_ALERT_SUMMARY, 8'h10);
		{attached_channel_pin_in, sink_current_in} = 3'h6;
		connection_state_code_in = 5'h15;
		tick(6);
		rd(`ADDR_OP_STATUS, 8'hD5);
		check_pin(orientation_out, 1'b1);
		check_pin(alert_n_out, 1'b1);
		partner_attached_in = 1'b1;
		tick(8);
		check_pin(analog_power_on_out, 1'b1);
		rd(`ADDR_CONN_STATUS, 8'h31);
		partner_attached_in = 1'b0;
		for (int i = 0; i < 10 && plug_power_discharge_out !== 1'b1; i++)
			tick(1);
		check_pin(plug_power_discharge_out, 1'b1);
		tick(DIS + 2);
		check_pin(plug_power_discharge_out, 1'b0);
		check_pin(analog_power_on_out, 1'b0);
		rd(`ADDR_CONN_CHANGE, 8'h01);
		rd(`ADDR_ALERT_SUMMARY, 8'h40);
		host.access({`DEV_ADDR_HIGH, ~addr0_in}, `ADDR_CAP_CTRL, 8'h00, 1'b0);
		check_pin(nacked, 1'b1);
		rd(`ADDR_CAP_CTRL, {eo, 6'h31});
		{active_role_in, supply_near_zero_in} = 2'h2;
		tick(12);
		check_pin(attach_qualified_out, 1'b0);
		{active_role_in, supply_near_zero_in} = 2'h1;
		tick(20);
		print_verdict();
	end
endmodule : tb_top

// ---- typec_regs_cfg.svh ----
// Register offsets, slave address, state codes, field limits, reset values and timing for the port
`ifndef TYPEC_REGS_CFG_SVH
`define TYPEC_REGS_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_ALERT_SUMMARY   8'h0B
`define ADDR_ALERT_MASK      8'h0C
`define ADDR_CONN_CHANGE     8'h0D
`define ADDR_CONN_STATUS     8'h0E
`define ADDR_MON_CHANGE      8'h0F
`define ADDR_MON_STATUS      8'h10
`define ADDR_OP_STATUS       8'h11
`define ADDR_FAULT_CHANGE    8'h12
`define ADDR_FAULT_STATUS    8'h13
`define ADDR_CAP_CTRL        8'h18
`define ADDR_SWITCH_LIMIT    8'h1E
`define ADDR_PLUG_MON_CTRL   8'h20

// ----------------------------------------------------------------------
// Slave address, state codes, field limits
// ----------------------------------------------------------------------
`define DEV_ADDR_HIGH        6'h14
`define STATE_SINK_UNATT     5'h00
`define STATE_SOURCE_UNATT   5'h08
`define OFFER_UNUSED         2'h3
`define LIMIT_CODE_MAX       4'hA
`define BITS_PER_BYTE        4'h8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_OFFER            2'h0
`define RST_DISCHARGE_EN     1'h0
`define RST_SUPPLY_EN        1'h1
`define RST_LIMIT_CODE       4'h0
`define RST_MON_EN           1'h1
`define RST_THRESHOLD_SEL    1'h0
`define RST_ALERT_MASK       3'h7
`define RST_MON_STATUS       4'h4
`define RST_FAULT_STATUS     8'h40
`define RST_SYNC             13'h0404

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_HZ               20000000
`define DISCHARGE_MS         250
`define DISCHARGE_CYCLES     ((`CLK_HZ / 1000) * `DISCHARGE_MS)

`endif

// ---- typec_regs_pkg.sv ----
// Types shared by the port controller register bank
package typec_regs_pkg;

	typedef enum logic [3:0] {
		I2C_IDLE,
		I2C_DEV_ADDR,
		I2C_DEV_ACK,
		I2C_REG_ADDR,
		I2C_REG_ACK,
		I2C_WRITE_DATA,
		I2C_WRITE_ACK,
		I2C_READ_DATA,
		I2C_READ_ACK
	} i2c_state_type;

	typedef struct packed {
		i2c_state_type i2c_state;
		logic          scl_last;
		logic          sda_last;
		logic [3:0]    bit_cnt;
		logic [7:0]    shift;
		logic          read_mode;
		logic [7:0]    pointer;
		logic          sda_oe;
		logic          primed;
		logic [12:0]   sync1;
		logic [12:0]   sync2;
		logic [3:0]    mon_status;
		logic [7:0]    fault_status;
		logic [3:0]    mon_flags;
		logic [7:0]    fault_flags;
		logic          conn_flag;
		logic [7:0]    conn_status;
		logic [7:0]    op_status;
		logic [1:0]    offer;
		logic          discharge_en;
		logic          supply_en;
		logic [3:0]    limit_code;
		logic          mon_en;
		logic          threshold_sel;
		logic [2:0]    alert_mask;
		logic [2:0]    alert;
		logic          alert_n;
		logic          standby;
		logic          analog_on;
		logic          qualified;
		logic [22:0]   discharge_cnt;
		logic          discharge_on;
	} state_type;

endpackage : typec_regs_pkg

// ---- typec_status_control_regs.sv ----
// Status, change-flag and control registers behind an I2C slave port
`timescale 1ns/1ps
`include "typec_regs_cfg.svh"

module typec_status_control_regs
	import typec_regs_pkg::*;
#(
	parameter int unsigned DISCHARGE_CYCLES = `DISCHARGE_CYCLES
) (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_out,
	input  wire logic       addr0_in,
	input  wire logic       supply_in_range_in,
	input  wire logic       supply_near_zero_in,
	input  wire logic       supply_present_in,
	input  wire logic       plug_power_above_in,
	input  wire logic       pullup_overvoltage_in,
	input  wire logic       pullup_good_in,
	input  wire logic [5:0] switch_fault_in,
	input  wire logic       thermal_over_in,
	input  wire logic       partner_attached_in,
	input  wire logic [2:0] attached_mode_in,
	input  wire logic       active_role_in,
	input  wire logic       plug_power_supplied_in,
	input  wire logic       attached_channel_pin_in,
	input  wire logic [1:0] sink_current_in,
	input  wire logic [4:0] connection_state_code_in,
	input  wire logic       nvm_standby_in,
	input  wire logic [1:0] nvm_offer_in,
	input  wire logic       nvm_discharge_en_in,
	input  wire logic       nvm_supply_en_in,
	input  wire logic [3:0] nvm_limit_code_in,
	input  wire logic [2:0] nvm_alert_mask_in,
	output logic            alert_n_out,
	output logic            analog_power_on_out,
	output logic            attach_qualified_out,
	output logic            orientation_out,
	output logic [1:0]      source_current_offer_out,
	output logic            plug_power_supply_enable_out,
	output logic            plug_power_discharge_out,
	output logic [3:0]      switch_current_limit_code_out,
	output logic            plug_power_monitor_enable_out,
	output logic            plug_power_threshold_select_out
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	// All state lives in one struct; s is registered, n is its next value
	state_type   s;
	state_type   n;
	logic [12:0] raw;
	logic [3:0]  mon_new;
	logic [3:0]  mon_chg;
	logic [7:0]  flt_chg;
	logic [7:0]  fault_evt;
	logic        conn_chg;
	logic        detach;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_cond;
	logic        stop_cond;
	logic        clr_mon;
	logic        clr_fault;
	logic        clr_conn;
	logic        clr_alert;
	logic        byte_done;
	logic [7:0]  rd_byte;
	logic [2:0]  alert_set;

	// ------------------------------------------------------------------
	// Register read map
	// ------------------------------------------------------------------
	// Reserved bits read as their fixed values; unmapped offsets read zero
	function automatic logic [7:0] read_reg(input state_type st,
		input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`ADDR_ALERT_SUMMARY: r = {1'b0, st.alert, 4'h0};
			`ADDR_ALERT_MASK:    r = {1'b1, st.alert_mask, 4'hF};
			`ADDR_CONN_CHANGE:   r = {7'h00, st.conn_flag};
			`ADDR_CONN_STATUS:   r = st.conn_status;
			`ADDR_MON_CHANGE:    r = {4'h0, st.mon_flags};
			`ADDR_MON_STATUS:    r = {4'h0, st.mon_status};
			`ADDR_OP_STATUS:     r = st.op_status;
			`ADDR_FAULT_CHANGE:  r = st.fault_flags;
			`ADDR_FAULT_STATUS:  r = st.fault_status;
			`ADDR_CAP_CTRL:      r = {st.offer, 1'b1, st.discharge_en,
				3'h0, st.supply_en};
			`ADDR_SWITCH_LIMIT:  r = {4'h0, st.limit_code};
			`ADDR_PLUG_MON_CTRL: r = {st.mon_en, st.threshold_sel, 1'b1,
				5'h00};
			default:             r = 8'h00;
		endcase
		return r;
	endfunction : read_reg

	// Comparator outputs are asynchronous to clk_in
	assign raw = {thermal_over_in, pullup_overvoltage_in, pullup_good_in,
		switch_fault_in, supply_in_range_in, supply_near_zero_in,
		supply_present_in, plug_power_above_in};

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		n          = s;
		rd_byte    = 8'h00;
		clr_mon    = 1'b0;
		clr_fault  = 1'b0;
		clr_conn   = 1'b0;
		clr_alert  = 1'b0;

		// --------------------------------------------------------------
		// Status capture and change detection
		// --------------------------------------------------------------
		n.sync1 = raw;
		n.sync2 = s.sync1;
		mon_new = {s.sync2[3:1], s.sync2[0] & s.mon_en};
		mon_chg = mon_new ^ s.mon_status;
		n.mon_status = mon_new;
		flt_chg = s.sync2[11:4] ^ s.fault_status;
		n.fault_status = s.sync2[11:4];
		fault_evt = {s.sync2[12], 1'b0, flt_chg[7], flt_chg[6], 1'b0,
			|flt_chg[5:4], |flt_chg[3:2], |flt_chg[1:0]};
		conn_chg = partner_attached_in ^ s.conn_status[0];
		detach = s.conn_status[0] & ~partner_attached_in;
		n.conn_status = {attached_mode_in, s.standby, active_role_in, 1'b0,
			plug_power_supplied_in, partner_attached_in};
		// Purely informative; it feeds no alert term below
		n.op_status = {attached_channel_pin_in, sink_current_in,
			connection_state_code_in};

		// --------------------------------------------------------------
		// Defaults captured once, on the first edge after reset release
		// --------------------------------------------------------------
		if (!s.primed) begin
			n.primed       = 1'b1;
			n.standby      = nvm_standby_in;
			n.offer        = nvm_offer_in;
			n.discharge_en = nvm_discharge_en_in;
			n.supply_en    = nvm_supply_en_in;
			n.limit_code   = nvm_limit_code_in;
			n.alert_mask   = nvm_alert_mask_in;
			n.op_status[4:0] = active_role_in ? `STATE_SOURCE_UNATT :
				`STATE_SINK_UNATT;
		end

		// --------------------------------------------------------------
		// I2C slave
		// --------------------------------------------------------------
		// START and STOP need SCL high on two successive samples, so an
		// SCL glitch shorter than one clock cannot open or close a frame
		n.scl_last = scl_in;
		n.sda_last = sda_in;
		scl_rise   = scl_in & ~s.scl_last;
		scl_fall   = ~scl_in & s.scl_last;
		start_cond = scl_in & s.scl_last & s.sda_last & ~sda_in;
		stop_cond  = scl_in & s.scl_last & ~s.sda_last & sda_in;
		byte_done  = (s.bit_cnt == `BITS_PER_BYTE);
		rd_byte    = read_reg(s, s.pointer);

		if (start_cond) begin
			n.i2c_state = I2C_DEV_ADDR;
			n.bit_cnt   = 4'h0;
			n.sda_oe    = 1'b0;
		end else if (stop_cond) begin
			n.i2c_state = I2C_IDLE;
			n.sda_oe    = 1'b0;
		end else if (scl_rise) begin
			if (s.i2c_state == I2C_DEV_ADDR || s.i2c_state == I2C_REG_ADDR
				|| s.i2c_state == I2C_WRITE_DATA) begin
				n.shift   = {s.shift[6:0], sda_in};
				n.bit_cnt = s.bit_cnt + 4'h1;
			end
		end else if (scl_fall) begin
			case (s.i2c_state)
				I2C_DEV_ADDR: begin
					if (byte_done) begin
						if (s.shift[7:1] == {`DEV_ADDR_HIGH, addr0_in}) begin
							n.i2c_state = I2C_DEV_ACK;
							n.read_mode = s.shift[0];
							n.sda_oe    = 1'b1;
						end else begin
							n.i2c_state = I2C_IDLE;
						end
					end
				end
				I2C_DEV_ACK, I2C_READ_ACK: begin
					if (s.i2c_state == I2C_READ_ACK && s.sda_last) begin
						n.i2c_state = I2C_IDLE;
						n.sda_oe    = 1'b0;
					end else if (s.read_mode) begin
						// First data bit goes out here, so the count
						// starts at one rather than zero
						n.i2c_state = I2C_READ_DATA;
						n.shift     = rd_byte;
						n.sda_oe    = ~rd_byte[7];
						n.bit_cnt   = 4'h1;
						case (s.pointer)
							`ADDR_MON_CHANGE:    clr_mon   = 1'b1;
							`ADDR_FAULT_CHANGE:  clr_fault = 1'b1;
							`ADDR_CONN_CHANGE:   clr_conn  = 1'b1;
							`ADDR_ALERT_SUMMARY: clr_alert = 1'b1;
							default:             clr_mon   = 1'b0;
						endcase
					end else begin
						n.i2c_state = I2C_REG_ADDR;
						n.sda_oe    = 1'b0;
						n.bit_cnt   = 4'h0;
					end
				end
				I2C_REG_ADDR: begin
					if (byte_done) begin
						n.pointer   = s.shift;
						n.i2c_state = I2C_REG_ACK;
						n.sda_oe    = 1'b1;
					end
				end
				I2C_REG_ACK, I2C_WRITE_ACK: begin
					if (s.i2c_state == I2C_WRITE_ACK) begin
						n.pointer = s.pointer + 8'h01;
					end
					n.i2c_state = I2C_WRITE_DATA;
					n.sda_oe    = 1'b0;
					n.bit_cnt   = 4'h0;
				end
				I2C_WRITE_DATA: begin
					if (byte_done) begin
						n.i2c_state = I2C_WRITE_ACK;
						n.sda_oe    = 1'b1;
						case (s.pointer)
							`ADDR_ALERT_MASK: n.alert_mask = s.shift[6:4];
							`ADDR_CAP_CTRL: begin
								if (s.shift[7:6] != `OFFER_UNUSED) begin
									n.offer = s.shift[7:6];
								end
								n.discharge_en = s.shift[4];
								n.supply_en    = s.shift[0];
							end
							`ADDR_SWITCH_LIMIT: begin
								if (s.shift[3:0] <= `LIMIT_CODE_MAX) begin
									n.limit_code = s.shift[3:0];
								end
							end
							`ADDR_PLUG_MON_CTRL: begin
								n.mon_en        = s.shift[7];
								n.threshold_sel = s.shift[6];
							end
							// Fixed and unmapped offsets are still acknowledged
							default: n.sda_oe = 1'b1;
						endcase
					end
				end
				I2C_READ_DATA: begin
					if (byte_done) begin
						n.i2c_state = I2C_READ_ACK;
						n.sda_oe    = 1'b0;
						n.pointer   = s.pointer + 8'h01;
					end else begin
						n.shift   = {s.shift[6:0], 1'b0};
						n.sda_oe  = ~s.shift[6];
						n.bit_cnt = s.bit_cnt + 4'h1;
					end
				end
				default: n.i2c_state = I2C_IDLE;
			endcase
		end

		// --------------------------------------------------------------
		// Change flags and alert summary; a new event beats the clear
		// --------------------------------------------------------------
		n.mon_flags = (clr_mon ? 4'h0 : s.mon_flags) | mon_chg;
		n.fault_flags = (clr_fault ? 8'h00 : s.fault_flags)
			| fault_evt;
		n.conn_flag = (clr_conn ? 1'b0 : s.conn_flag) | conn_chg;
		alert_set = {conn_chg, |mon_chg, |fault_evt};
		n.alert = (clr_alert ? 3'h0 : s.alert) | alert_set;
		// Mask works on the next alert value, so the pin follows the flag
		// on the same edge instead of one clock later
		n.alert_n = ~|(n.alert & ~n.alert_mask);

		// --------------------------------------------------------------
		// Power and discharge control
		// --------------------------------------------------------------
		// Standby keeps analog blocks off only until a partner appears
		n.analog_on = ~n.standby | partner_attached_in;
		// Sink role needs no qualification; source waits for near-zero
		n.qualified = ~n.conn_status[3]
			| n.mon_status[2];
		// A new detach restarts the pulse; a reconnect does not cut it
		// short, which trades a longer discharge for a simpler counter
		if (detach && s.discharge_en) begin
			n.discharge_cnt = 23'(DISCHARGE_CYCLES);
		end else if (s.discharge_cnt != 23'h000000) begin
			n.discharge_cnt = s.discharge_cnt - 23'h000001;
		end
		n.discharge_on = (n.discharge_cnt != 23'h000000);
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '{i2c_state: I2C_IDLE, scl_last: 1'b1, sda_last: 1'b1,
				sync1: `RST_SYNC, sync2: `RST_SYNC,
				mon_status: `RST_MON_STATUS,
				fault_status: `RST_FAULT_STATUS,
				offer: `RST_OFFER, discharge_en: `RST_DISCHARGE_EN,
				supply_en: `RST_SUPPLY_EN, limit_code: `RST_LIMIT_CODE,
				mon_en: `RST_MON_EN, threshold_sel: `RST_THRESHOLD_SEL,
				alert_mask: `RST_ALERT_MASK, alert_n: 1'b1,
				qualified: 1'b1,
				default: '0};
		end else begin
			s <= n;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Open drain: data output is always low, the enable pulls the line
	assign sda_out    = 1'b0;
	assign sda_oe_out = s.sda_oe;
	assign alert_n_out = s.alert_n;
	assign analog_power_on_out = s.analog_on;
	// Role bit is read whether or not a partner is attached
	assign attach_qualified_out = s.qualified;
	assign orientation_out = s.op_status[7];
	assign source_current_offer_out = s.offer;
	assign plug_power_supply_enable_out = s.supply_en;
	assign plug_power_discharge_out = s.discharge_on;
	assign switch_current_limit_code_out = s.limit_code;
	assign plug_power_monitor_enable_out = s.mon_en;
	assign plug_power_threshold_select_out = s.threshold_sel;

endmodule : typec_status_control_regs

// ---- typec_status_control_regs_asserts.sv ----
// Port-level checks on the register bank
`timescale 1ns/1ps
module typec_status_control_regs_asserts #(
	parameter int unsigned DISCHARGE_CYCLES = 20
) (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       scl_in,
	input wire logic       supply_near_zero_in,
	input wire logic       partner_attached_in,
	input wire logic       active_role_in,
	input wire logic       attached_channel_pin_in,
	input wire logic       nvm_standby_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_out,
	input wire logic       analog_power_on_out,
	input wire logic       attach_qualified_out,
	input wire logic       orientation_out,
	input wire logic [1:0] source_current_offer_out,
	input wire logic       plug_power_discharge_out,
	input wire logic [3:0] switch_current_limit_code_out,
	input wire logic       plug_power_monitor_enable_out,
	input wire logic       plug_power_threshold_select_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	// Length of the running discharge pulse
	logic [31:0] dis_cnt_reg;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			dis_cnt_reg <= 32'h0;
		else if (plug_power_discharge_out)
			dis_cnt_reg <= dis_cnt_reg + 32'h1;
		else
			dis_cnt_reg <= 32'h0;
	end

	a_sda_only_low: assert property (sda_out == 1'b0)
		else $error("data line driven high");
	a_ack_after_fall: assert property ($rose(sda_oe_out) |->
		!scl_in && !$past(scl_in)) else $error("data driven while SCL high");
	a_offer_legal: assert property (source_current_offer_out != 2'h3)
		else $error("unused offer code");
	a_limit_legal: assert property (switch_current_limit_code_out <= 4'hA)
		else $error("undefined limit code");
	a_sink_qualified: assert property ((!active_role_in)[*3] |->
		attach_qualified_out) else $error("sink attach not qualified");
	a_source_waits_zero: assert property (
		(active_role_in && !supply_near_zero_in)[*6] |-> !attach_qualified_out)
		else $error("source qualified without near-zero supply");
	a_orient_high: assert property (attached_channel_pin_in[*4] |->
		orientation_out) else $error("orientation not high");
	a_orient_low: assert property ((!attached_channel_pin_in)[*4] |->
		!orientation_out) else $error("orientation not low");
	a_standby_dark: assert property (
		(nvm_standby_in && !partner_attached_in)[*4] |-> !analog_power_on_out)
		else $error("analog powered while idle in standby");
	a_attached_lit: assert property (partner_attached_in[*4] |->
		analog_power_on_out) else $error("analog off while attached");
	a_discharge_length: assert property ($fell(plug_power_discharge_out) |->
		dis_cnt_reg == DISCHARGE_CYCLES) else $error("discharge length wrong");
	a_discharge_bound: assert property (dis_cnt_reg <= DISCHARGE_CYCLES)
		else $error("discharge too long");
	a_discharge_cause: assert property ($rose(plug_power_discharge_out) |->
		!partner_attached_in) else $error("discharge while attached");
	a_monitor_reset: assert property ($rose(rst_n_in) |->
		plug_power_monitor_enable_out && !plug_power_threshold_select_out)
		else $error("monitor control reset value wrong");
endmodule : typec_status_control_regs_asserts

bind typec_status_control_regs typec_status_control_regs_asserts
	#(.DISCHARGE_CYCLES(DISCHARGE_CYCLES)) u_asserts (.*);
